// file: hdl/siww_dev.sv
// Fail-safe device end: init phase, protected configuration, window watchdog
// Assumes the link master never reads and writes in the same cycle
// Behaviour
// - Init phase entered after reset pin release
// - Host writes value then its inverse
// - Data and complement compared every cycle
// - Reserved bits excluded from comparison
// - Mismatch flag cleared on pass, set on fail
// - Mismatch monitoring active only after init closes
// - Init must close within 256 ms
// - Return request re-enters init from later states
// - Host sends return request after good refresh (code sends it after any answer write flagged REINIT, good or bad)
// - Window is closed part then open part
// - Good refresh: right answer in open part
// - Bad: wrong, missing, or early right answer (code ignores a wrong answer in the closed part)
// - Any refresh restarts window from closed part
// - First good refresh closes init phase
// - Four-bit selector picks 1 to 1024 ms
// - New period applies after next refresh
// - Disable accepted in init, effective at closure
// - Window config written as value plus inverse
// - Selector decode, default 3 ms, zero disables
// - Duty selector sets closed share, after refresh
//
// Local design decisions: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
module siww_dev #(
    parameter int TICK_CYCLES = siww_pkg::TICK_CYCLES
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic wake_req,
    siww_if.dev lnk,
    output logic init_phase,
    output logic wd_good,
    output logic wd_bad,
    output logic wd_open,
    output logic init_fault,
    output logic mismatch_fault
);
    siww_pkg::siww_dstate_t state_ff;
    logic rst_out_ff;
    logic [15:0] init_data_ff;
    logic [15:0] init_cmpl_ff;
    logic [15:0] win_cfg_ff;
    logic [15:0] win_inv_ff;
    logic [3:0] act_per_ff;
    logic [2:0] act_duty_ff;
    logic [14:0] win_cnt_ff;
    logic [15:0] init_cnt_ff;
    logic wd_off_ff;
    logic mismatch_ff;
    logic timeout_ff;
    logic last_bad_ff;
    logic [15:0] rdata_ff;
    logic rvalid_ff;
    logic init_phase_ff;
    logic wd_good_ff;
    logic wd_bad_ff;
    logic wd_open_ff;
    logic mismatch_fault_ff;
    logic tick;

    logic wr;
    logic rd;
    logic in_init;
    logic supervise;
    logic [3:0] eff_per;
    logic [14:0] per_ticks;
    logic [14:0] closed_ticks;
    logic open_now;
    logic ans;
    logic ans_ok;
    logic expire;
    logic good;
    logic bad;
    logic refresh;
    logic ret_req;
    logic [3:0] nxt_per_field;

    siww_tick #(.CYCLES(TICK_CYCLES)) u_tick (
        .clk(clk),
        .reset(reset),
        .tick(tick)
    );

    assign wr = lnk.req & lnk.we;
    assign rd = lnk.req & ~lnk.we;
    assign in_init = (state_ff == siww_pkg::DS_INIT);
    assign supervise = in_init | ((state_ff == siww_pkg::DS_RUN) & ~wd_off_ff);

    // Disabled code still times the window while in init
    assign eff_per = (act_per_ff == siww_pkg::PER_OFF) ? siww_pkg::PER_RST : act_per_ff;
    assign per_ticks = 15'(siww_pkg::period_ms(eff_per)) * 15'(siww_pkg::TICKS_PER_MS);
    assign closed_ticks = 15'(siww_pkg::period_ms(eff_per))
                          * 15'(siww_pkg::closed16(act_duty_ff));
    assign open_now = (win_cnt_ff >= closed_ticks);

    assign ans = supervise & wr & (lnk.addr == siww_pkg::ADDR_WD_ANSWER);
    assign ans_ok = (lnk.wdata == siww_pkg::WD_ANSWER_OK);
    assign expire = supervise & tick & (win_cnt_ff >= per_ticks - 15'd1);
    assign good = ans & ans_ok & open_now;
    assign bad = (ans & ((open_now & ~ans_ok) | (~open_now & ans_ok))) | (expire & ~good);
    assign refresh = good | bad;
    assign ret_req = wr & (lnk.addr == siww_pkg::ADDR_SAFE_IOS)
                     & lnk.wdata[siww_pkg::RET_INIT_BIT];

    // Outside init a disable code keeps the previous period
    assign nxt_per_field = (~in_init && lnk.wdata[siww_pkg::PER_LSB +: 4] == siww_pkg::PER_OFF)
                           ? win_cfg_ff[siww_pkg::PER_LSB +: 4]
                           : lnk.wdata[siww_pkg::PER_LSB +: 4];

    // Safety state machine and reset pin
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_ff <= siww_pkg::DS_HOLD;
            rst_out_ff <= 1'b0;
            wd_off_ff <= 1'b0;
        end else if (wake_req) begin
            state_ff <= siww_pkg::DS_HOLD;
            rst_out_ff <= 1'b0;
            wd_off_ff <= 1'b0;
        end else begin
            unique case (state_ff)
                siww_pkg::DS_HOLD: begin
                    rst_out_ff <= 1'b1;
                    if (rst_out_ff) begin
                        state_ff <= siww_pkg::DS_INIT;
                    end
                end
                siww_pkg::DS_INIT: begin
                    if (good) begin
                        state_ff <= siww_pkg::DS_RUN;
                        wd_off_ff <= (win_cfg_ff[siww_pkg::PER_LSB +: 4]
                                      == siww_pkg::PER_OFF);
                    end
                end
                siww_pkg::DS_RUN: begin
                    if (ret_req) begin
                        state_ff <= siww_pkg::DS_INIT;
                        wd_off_ff <= 1'b0;
                    end
                end
            endcase
        end
    end

    // Window counter and settings that apply per window
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            win_cnt_ff <= '0;
            act_per_ff <= siww_pkg::PER_RST;
            act_duty_ff <= siww_pkg::DUTY_RST;
        end else if (refresh || !supervise || (state_ff == siww_pkg::DS_RUN && ret_req)) begin
            win_cnt_ff <= '0;
            act_per_ff <= win_cfg_ff[siww_pkg::PER_LSB +: 4];
            act_duty_ff <= win_cfg_ff[siww_pkg::DUTY_LSB +: 3];
        end else if (tick) begin
            win_cnt_ff <= win_cnt_ff + 15'd1;
        end
    end

    // Init phase time limit
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            init_cnt_ff <= '0;
            timeout_ff <= 1'b0;
        end else if (!in_init) begin
            init_cnt_ff <= '0;
        end else if (tick && !good) begin
            if (init_cnt_ff == siww_pkg::INIT_LIMIT_TICKS - 16'd1) begin
                timeout_ff <= 1'b1;
            end else begin
                init_cnt_ff <= init_cnt_ff + 16'd1;
            end
        end
    end

    // Protected configuration registers
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            init_data_ff <= siww_pkg::INIT_DATA_RST;
            init_cmpl_ff <= siww_pkg::INIT_CMPL_RST;
            win_cfg_ff <= siww_pkg::WIN_CFG_RST;
            win_inv_ff <= siww_pkg::WIN_INV_RST;
        end else if (wr) begin
            if (in_init && lnk.addr == siww_pkg::ADDR_INIT_DATA) begin
                init_data_ff <= lnk.wdata;
            end
            if (in_init && lnk.addr == siww_pkg::ADDR_INIT_CMPL) begin
                init_cmpl_ff <= lnk.wdata;
            end
            if (lnk.addr == siww_pkg::ADDR_WIN_CFG) begin
                win_cfg_ff <= {lnk.wdata[15:4], nxt_per_field};
            end
            if (lnk.addr == siww_pkg::ADDR_WIN_INV) begin
                win_inv_ff <= lnk.wdata;
            end
        end
    end

    // Continuous pair comparison and fault flags
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            mismatch_ff <= 1'b0;
            mismatch_fault_ff <= 1'b0;
            last_bad_ff <= 1'b0;
        end else begin
            mismatch_ff <= ~(siww_pkg::pair_ok(init_data_ff, init_cmpl_ff, siww_pkg::INIT_MASK)
                             & siww_pkg::pair_ok(win_cfg_ff, win_inv_ff,
                                                 siww_pkg::WIN_MASK));
            mismatch_fault_ff <= mismatch_ff & (state_ff == siww_pkg::DS_RUN);
            if (bad) begin
                last_bad_ff <= 1'b1;
            end else if (good) begin
                last_bad_ff <= 1'b0;
            end
        end
    end

    // Link read answers, one cycle after the request
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rdata_ff <= '0;
            rvalid_ff <= 1'b0;
        end else begin
            rvalid_ff <= rd;
            if (rd) begin
                unique case (lnk.addr)
                    siww_pkg::ADDR_INIT_DATA: rdata_ff <= init_data_ff;
                    siww_pkg::ADDR_INIT_CMPL: rdata_ff <= init_cmpl_ff;
                    siww_pkg::ADDR_WIN_CFG: rdata_ff <= win_cfg_ff;
                    siww_pkg::ADDR_WIN_INV: rdata_ff <= win_inv_ff;
                    siww_pkg::ADDR_STATUS: begin
                        rdata_ff <= '0;
                        rdata_ff[siww_pkg::ST_MISMATCH] <= mismatch_ff;
                        rdata_ff[siww_pkg::ST_INIT] <= in_init;
                        rdata_ff[siww_pkg::ST_TIMEOUT] <= timeout_ff;
                        rdata_ff[siww_pkg::ST_OPEN] <= open_now;
                        rdata_ff[siww_pkg::ST_WD_OFF] <= wd_off_ff;
                        rdata_ff[siww_pkg::ST_LAST_BAD] <= last_bad_ff;
                    end
                    default: rdata_ff <= '0;
                endcase
            end
        end
    end

    // Registered user outputs
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            init_phase_ff <= 1'b0;
            wd_good_ff <= 1'b0;
            wd_bad_ff <= 1'b0;
            wd_open_ff <= 1'b0;
        end else begin
            init_phase_ff <= in_init;
            wd_good_ff <= good;
            wd_bad_ff <= bad;
            wd_open_ff <= supervise & open_now;
        end
    end

    assign lnk.rdata = rdata_ff;
    assign lnk.rvalid = rvalid_ff;
    assign lnk.rst_out_n = rst_out_ff;
    assign init_phase = init_phase_ff;
    assign wd_good = wd_good_ff;
    assign wd_bad = wd_bad_ff;
    assign wd_open = wd_open_ff;
    assign init_fault = timeout_ff;
    assign mismatch_fault = mismatch_fault_ff;
endmodule

// file: hdl/siww_pkg.sv
// Shared constants, types and helpers for the safety init / window watchdog pair
// Assumes a single 100 MHz clock shared by both ends
package siww_pkg;
    // Clock and time base
    localparam int CLK_NS = 10;
    localparam int TICK_NS = 62500;
    localparam int TICK_CYCLES = (TICK_NS + CLK_NS - 1) / CLK_NS;
    localparam int TICKS_PER_MS = 16;
    localparam int INIT_LIMIT_MS = 256;
    localparam logic [15:0] INIT_LIMIT_TICKS = 16'(INIT_LIMIT_MS * TICKS_PER_MS);

    // Device register addresses on the link
    localparam logic [7:0] ADDR_INIT_DATA = 8'h00;
    localparam logic [7:0] ADDR_INIT_CMPL = 8'h01;
    localparam logic [7:0] ADDR_WIN_CFG = 8'h02;
    localparam logic [7:0] ADDR_WIN_INV = 8'h03;
    localparam logic [7:0] ADDR_SAFE_IOS = 8'h04;
    localparam logic [7:0] ADDR_WD_ANSWER = 8'h05;
    localparam logic [7:0] ADDR_STATUS = 8'h06;

    // Functional bit masks, reserved bits are zero
    localparam logic [15:0] INIT_MASK = 16'h7fff;
    localparam logic [15:0] WIN_MASK = 16'h007f;

    // Window configuration fields and reset values
    localparam int PER_LSB = 0;
    localparam int DUTY_LSB = 4;
    localparam logic [3:0] PER_RST = 4'h3;
    localparam logic [3:0] PER_OFF = 4'h0;
    localparam logic [2:0] DUTY_RST = 3'h2;
    localparam logic [15:0] WIN_CFG_RST = 16'h0023;
    localparam logic [15:0] WIN_INV_RST = 16'h005c;
    localparam logic [15:0] INIT_DATA_RST = 16'h0000;
    localparam logic [15:0] INIT_CMPL_RST = 16'h7fff;
    localparam int RET_INIT_BIT = 0;
    localparam logic [15:0] WD_ANSWER_OK = 16'h5ab2;

    // Status register bits
    localparam int ST_MISMATCH = 0;
    localparam int ST_INIT = 1;
    localparam int ST_TIMEOUT = 2;
    localparam int ST_OPEN = 3;
    localparam int ST_WD_OFF = 4;
    localparam int ST_LAST_BAD = 5;

    // Host register addresses and command fields
    localparam logic [7:0] HADDR_CMD = 8'h00;
    localparam logic [7:0] HADDR_WDATA = 8'h01;
    localparam logic [7:0] HADDR_STAT = 8'h02;
    localparam logic [7:0] HADDR_RDATA = 8'h03;
    localparam int CMD_PROT = 8;
    localparam int CMD_READ = 9;
    localparam int CMD_REINIT = 10;

    typedef enum logic [1:0] {DS_HOLD, DS_INIT, DS_RUN} siww_dstate_t;
    typedef enum logic [2:0] {HS_IDLE, HS_FIRST, HS_SECOND, HS_REINIT, HS_READ} siww_hstate_t;

    // Window period in ms per selector code
    function automatic logic [10:0] period_ms(input logic [3:0] sel);
        unique case (sel)
            4'h0, 4'h3: period_ms = 11'd3;
            4'h1: period_ms = 11'd1;
            4'h2: period_ms = 11'd2;
            4'h4: period_ms = 11'd4;
            4'h5: period_ms = 11'd6;
            4'h6: period_ms = 11'd8;
            4'h7: period_ms = 11'd12;
            4'h8: period_ms = 11'd16;
            4'h9: period_ms = 11'd24;
            4'ha: period_ms = 11'd32;
            4'hb: period_ms = 11'd64;
            4'hc: period_ms = 11'd128;
            4'hd: period_ms = 11'd256;
            4'he: period_ms = 11'd512;
            4'hf: period_ms = 11'd1024;
        endcase
    endfunction

    // Closed share in sixteenths per duty code
    function automatic logic [3:0] closed16(input logic [2:0] duty);
        case (duty)
            3'h0: closed16 = 4'd5;
            3'h1: closed16 = 4'd6;
            3'h3: closed16 = 4'd10;
            3'h4: closed16 = 4'd11;
            default: closed16 = 4'd8;
        endcase
    endfunction

    // Every functional bit must be the inverse of its partner
    function automatic logic pair_ok(input logic [15:0] a, input logic [15:0] b,
                                     input logic [15:0] mask);
        pair_ok = ((a ^ b) & mask) == mask;
    endfunction
endpackage

// file: hdl/siww_if.sv
// Link between the microcontroller end and the fail-safe device end
// Assumes both ends run on the same clock
`timescale 1ns/10ps
interface siww_if;
    logic req;
    logic we;
    logic [7:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic rvalid;
    logic rst_out_n;

    modport dev(input req, input we, input addr, input wdata,
                output rdata, output rvalid, output rst_out_n);
    modport host(output req, output we, output addr, output wdata,
                 input rdata, input rvalid, input rst_out_n);
endinterface

// file: hdl/siww_tick.sv
// Free running prescaler giving one pulse per watchdog time step
// Assumes the system clock and asynchronous active high reset
`timescale 1ns/10ps
module siww_tick #(
    parameter int CYCLES = siww_pkg::TICK_CYCLES
) (
    input wire logic clk,
    input wire logic reset,
    output logic tick
);
    localparam int W = $clog2(CYCLES);
    localparam logic [W-1:0] LAST = W'(CYCLES - 1);

    logic [W-1:0] cnt_ff;
    logic tick_ff;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cnt_ff <= '0;
            tick_ff <= 1'b0;
        end else begin
            tick_ff <= (cnt_ff == LAST);
            cnt_ff <= (cnt_ff == LAST) ? '0 : cnt_ff + 1'b1;
        end
    end

    assign tick = tick_ff;
endmodule

// file: hdl/siww_host.sv
// Microcontroller end: turns software commands into link transfers
// Assumes software polls the busy bit before issuing a new command
`timescale 1ns/10ps
module siww_host (
    input wire logic clk,
    input wire logic reset,
    siww_if.host lnk,
    input wire logic [7:0] sw_addr,
    input wire logic [15:0] sw_wdata,
    input wire logic sw_wr,
    input wire logic sw_rd,
    output logic [15:0] sw_rdata
);
    siww_pkg::siww_hstate_t state_ff;
    logic [10:0] cmd_ff;
    logic [15:0] wdata_ff;
    logic [15:0] rdata_ff;
    logic [15:0] sw_rdata_ff;
    logic req_ff;
    logic we_ff;
    logic [7:0] addr_ff;
    logic [15:0] lwdata_ff;
    logic start;
    logic idle;

    assign idle = (state_ff == siww_pkg::HS_IDLE);
    assign start = sw_wr & (sw_addr == siww_pkg::HADDR_CMD) & idle & lnk.rst_out_n;

    // Command sequencer and link drive
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_ff <= siww_pkg::HS_IDLE;
            req_ff <= 1'b0;
            we_ff <= 1'b0;
            addr_ff <= '0;
            lwdata_ff <= '0;
            rdata_ff <= '0;
        end else begin
            req_ff <= 1'b0;
            unique case (state_ff)
                siww_pkg::HS_IDLE: begin
                    if (start) begin
                        state_ff <= siww_pkg::HS_FIRST;
                    end
                end
                siww_pkg::HS_FIRST: begin
                    req_ff <= 1'b1;
                    we_ff <= ~cmd_ff[siww_pkg::CMD_READ];
                    addr_ff <= cmd_ff[7:0];
                    lwdata_ff <= wdata_ff;
                    if (cmd_ff[siww_pkg::CMD_READ]) begin
                        state_ff <= siww_pkg::HS_READ;
                    end else if (cmd_ff[siww_pkg::CMD_PROT]) begin
                        state_ff <= siww_pkg::HS_SECOND;
                    end else if (cmd_ff[siww_pkg::CMD_REINIT]
                                 && cmd_ff[7:0] == siww_pkg::ADDR_WD_ANSWER) begin
                        state_ff <= siww_pkg::HS_REINIT;
                    end else begin
                        state_ff <= siww_pkg::HS_IDLE;
                    end
                end
                siww_pkg::HS_SECOND: begin
                    req_ff <= 1'b1;
                    addr_ff <= cmd_ff[7:0] + 8'h01;
                    lwdata_ff <= ~wdata_ff;
                    state_ff <= siww_pkg::HS_IDLE;
                end
                siww_pkg::HS_REINIT: begin
                    req_ff <= 1'b1;
                    addr_ff <= siww_pkg::ADDR_SAFE_IOS;
                    lwdata_ff <= 16'h0001 << siww_pkg::RET_INIT_BIT;
                    state_ff <= siww_pkg::HS_IDLE;
                end
                siww_pkg::HS_READ: begin
                    if (lnk.rvalid) begin
                        rdata_ff <= lnk.rdata;
                        state_ff <= siww_pkg::HS_IDLE;
                    end
                end
                default: state_ff <= siww_pkg::HS_IDLE;
            endcase
        end
    end

    // Software registers
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cmd_ff <= '0;
            wdata_ff <= '0;
            sw_rdata_ff <= '0;
        end else begin
            if (start) begin
                cmd_ff <= sw_wdata[10:0];
            end
            if (sw_wr && sw_addr == siww_pkg::HADDR_WDATA && idle) begin
                wdata_ff <= sw_wdata;
            end
            if (sw_rd) begin
                unique case (sw_addr)
                    siww_pkg::HADDR_CMD: sw_rdata_ff <= {5'h00, cmd_ff};
                    siww_pkg::HADDR_WDATA: sw_rdata_ff <= wdata_ff;
                    siww_pkg::HADDR_STAT: sw_rdata_ff <= {14'h0000, lnk.rst_out_n, ~idle};
                    siww_pkg::HADDR_RDATA: sw_rdata_ff <= rdata_ff;
                    default: sw_rdata_ff <= '0;
                endcase
            end
        end
    end

    assign lnk.req = req_ff;
    assign lnk.we = we_ff;
    assign lnk.addr = addr_ff;
    assign lnk.wdata = lwdata_ff;
    assign sw_rdata = sw_rdata_ff;
endmodule

// file: tb/siww_chk.sv
// Concurrent checks on the link between the two ends
// Assumes it is instantiated beside the link interface in the bench top
`timescale 1ns/10ps
module siww_chk (
    input wire logic clk,
    input wire logic reset,
    input wire logic req,
    input wire logic we,
    input wire logic [7:0] addr,
    input wire logic [15:0] wdata,
    input wire logic [15:0] rdata,
    input wire logic rvalid,
    input wire logic rst_out_n
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    // Answer to a status read
    sequence s_stat;
        rvalid && $past(addr) == siww_pkg::ADDR_STATUS;
    endsequence

    property p_read_ans;
        req && !we |=> rvalid;
    endproperty
    property p_rvalid_cause;
        rvalid |-> $past(req && !we);
    endproperty
    property p_rdata_hold;
        !rvalid |-> $stable(rdata);
    endproperty
    property p_rst_pulse;
        !rst_out_n |=> rst_out_n;
    endproperty
    property p_req_rst;
        req |-> rst_out_n;
    endproperty
    property p_pair_init;
        req && we && addr == siww_pkg::ADDR_INIT_CMPL
            && $past(req && we && addr == siww_pkg::ADDR_INIT_DATA) |-> wdata == ~$past(wdata);
    endproperty
    property p_tmo_init;
        s_stat ##0 rdata[siww_pkg::ST_TIMEOUT] |-> rdata[siww_pkg::ST_INIT];
    endproperty
    property p_off_closed;
        s_stat ##0 rdata[siww_pkg::ST_WD_OFF] |-> !rdata[siww_pkg::ST_OPEN];
    endproperty

    a_read_ans: assert property (p_read_ans) else $error("read without answer");
    a_rvalid_cause: assert property (p_rvalid_cause) else $error("stray answer");
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
    a_rst_pulse: assert property (p_rst_pulse) else $error("reset pin stuck low");
    a_req_rst: assert property (p_req_rst) else $error("request while in reset");
    a_pair_init: assert property (p_pair_init) else $error("pair not inverse");
    a_tmo_init: assert property (p_tmo_init) else $error("timeout outside init");
    a_off_closed: assert property (p_off_closed) else $error("open while off");

    c_stat_init: cover property (s_stat ##0 rdata[siww_pkg::ST_INIT]);
    c_answer: cover property (req && we && addr == siww_pkg::ADDR_WD_ANSWER);
    c_timeout: cover property (s_stat ##0 rdata[siww_pkg::ST_TIMEOUT]);
endmodule

// file: tb/safety_init_window_watchdog_test.sv
// Bench for the init phase and window watchdog pair
// Assumes package, link interface and both ends are compiled first
`timescale 1ns/10ps
module safety_init_window_watchdog_test;
    localparam int TC = 4;
    localparam logic [15:0] PROT = 16'h0100;
    localparam logic [15:0] RD = 16'h0200;
    localparam logic [15:0] REINIT = 16'h0400;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] sw_addr = 8'h00;
    logic [15:0] sw_wdata = 16'h0000;
    logic sw_wr = 1'b0;
    logic sw_rd = 1'b0;
    logic wake_req = 1'b0;
    logic [15:0] sw_rdata;
    logic init_phase, wd_good, wd_bad, wd_open, init_fault, mismatch_fault;
    logic [15:0] v;
    int n_fail = 0;
    int n_tests = 0;
    int n_good = 0;
    int n_bad = 0;
    int t;
    time t_ref = 0;

    siww_if i_siww_if();
    siww_dev #(.TICK_CYCLES(TC)) i_siww_dev(.clk(clk), .reset(reset), .wake_req(wake_req),
        .lnk(i_siww_if.dev), .init_phase(init_phase), .wd_good(wd_good), .wd_bad(wd_bad),
        .wd_open(wd_open), .init_fault(init_fault), .mismatch_fault(mismatch_fault));
    siww_host i_siww_host(.clk(clk), .reset(reset), .lnk(i_siww_if.host), .sw_addr(sw_addr),
        .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata));
    siww_chk i_siww_chk(.clk(clk), .reset(reset), .req(i_siww_if.req), .we(i_siww_if.we),
        .addr(i_siww_if.addr), .wdata(i_siww_if.wdata), .rdata(i_siww_if.rdata),
        .rvalid(i_siww_if.rvalid), .rst_out_n(i_siww_if.rst_out_n));

    initial begin
        forever #5 clk = ~clk;
    end

    // Refresh pulse counters and time of last refresh
    always @(posedge clk) begin
        if (wd_good === 1'b1 || wd_bad === 1'b1)
            t_ref = $time;
        if (wd_good === 1'b1)
            n_good++;
        if (wd_bad === 1'b1)
            n_bad++;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic sw_write(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        sw_addr <= a;
        sw_wdata <= d;
        sw_wr <= 1'b1;
        @(posedge clk);
        sw_wr <= 1'b0;
    endtask

    task automatic sw_read(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk);
        sw_addr <= a;
        sw_rd <= 1'b1;
        @(posedge clk);
        sw_rd <= 1'b0;
        #1 d = sw_rdata;
    endtask

    // Issue one host command and poll until idle
    task automatic cmd(input logic [15:0] c, input logic [15:0] d);
        logic [15:0] s;
        int k;
        sw_write(siww_pkg::HADDR_WDATA, d);
        sw_write(siww_pkg::HADDR_CMD, c);
        s = 16'h0001;
        k = 0;
        while (s[0] !== 1'b0 && k < 20) begin
            sw_read(siww_pkg::HADDR_STAT, s);
            k++;
        end
        if (s[0] !== 1'b0) begin
            n_fail++;
        end
    endtask

    task automatic stat(output logic [15:0] d);
        cmd(RD | 16'(siww_pkg::ADDR_STATUS), 16'h0000);
        sw_read(siww_pkg::HADDR_RDATA, d);
    endtask

    // Wait for the start of an open part, not the tail of one
    task automatic wait_open();
        t = 0;
        while (wd_open === 1'b1 && t < 4000) begin
            @(posedge clk);
            #1 t++;
        end
        while (wd_open !== 1'b1 && t < 4000) begin
            @(posedge clk);
            #1 t++;
        end
        if (t >= 4000) begin
            n_fail++;
        end
    endtask

    // Refresh pulses and state outputs settle two cycles after the link write
    task automatic answer(input logic [15:0] f, input logic [15:0] d);
        cmd(f | 16'(siww_pkg::ADDR_WD_ANSWER), d);
        repeat (2) @(posedge clk);
        #1;
    endtask

    task automatic wrap_up();
        $display("tests %0d failures %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge clk);
        n_fail++;
        wrap_up();
    end

    initial begin
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        repeat (4) @(posedge clk);
        #1 check(init_phase, 1'b1);
        cmd(RD | 16'(siww_pkg::ADDR_WIN_CFG), 16'h0000);
        sw_read(siww_pkg::HADDR_RDATA, v);
        check(v, siww_pkg::WIN_CFG_RST);
        cmd(PROT | 16'(siww_pkg::ADDR_INIT_DATA), 16'h1234);
        stat(v);
        check(v[1:0], 2'b10);
        cmd(16'(siww_pkg::ADDR_INIT_CMPL), 16'h6dcb);
        stat(v);
        check(v[0], 1'b0);
        cmd(16'(siww_pkg::ADDR_INIT_CMPL), 16'h6dca);
        stat(v);
        check(v[0], 1'b1);
        check(mismatch_fault, 1'b0);
        cmd(PROT | 16'(siww_pkg::ADDR_INIT_DATA), 16'h1234);
        stat(v);
        check(v[0], 1'b0);
        // Period 1 ms, closed share 5/16
        cmd(PROT | 16'(siww_pkg::ADDR_WIN_CFG), 16'h0001);
        wait_open();
        answer(16'h0000, siww_pkg::WD_ANSWER_OK);
        check(16'(n_good), 16'h0001);
        check(init_phase, 1'b0);
        answer(16'h0000, siww_pkg::WD_ANSWER_OK);
        check(16'(n_bad), 16'h0001);
        wait_open();
        t = int'(($time - t_ref) / 10);
        check(t >= 13 && t <= 23, 1'b1);
        answer(16'h0000, 16'h0000);
        check(16'(n_bad), 16'h0002);
        repeat (100) @(posedge clk);
        #1 check(16'(n_bad), 16'h0003);
        cmd(16'(siww_pkg::ADDR_WIN_INV), 16'h0000);
        repeat (4) @(posedge clk);
        #1 check(mismatch_fault, 1'b1);
        cmd(16'(siww_pkg::ADDR_WIN_INV), 16'h007e);
        repeat (4) @(posedge clk);
        #1 check(mismatch_fault, 1'b0);
        wait_open();
        answer(REINIT, siww_pkg::WD_ANSWER_OK);
        repeat (4) @(posedge clk);
        #1 check(init_phase, 1'b1);
        cmd(PROT | 16'(siww_pkg::ADDR_WIN_CFG), 16'h0000);
        wait_open();
        answer(16'h0000, siww_pkg::WD_ANSWER_OK);
        stat(v);
        check(v[4:1], 4'b1000);
        cmd(16'(siww_pkg::ADDR_SAFE_IOS), 16'h0001);
        repeat (16300) @(posedge clk);
        #1 check(init_fault, 1'b0);
        repeat (200) @(posedge clk);
        #1 check(init_fault, 1'b1);
        stat(v);
        check(v[2:1], 2'b11);
        // Wake-up from standby: reset pin pulses low, init entered again
        @(posedge clk);
        wake_req <= 1'b1;
        @(posedge clk);
        wake_req <= 1'b0;
        #1 check(i_siww_if.rst_out_n, 1'b0);
        repeat (2) @(posedge clk);
        #1 check(init_phase, 1'b0);
        repeat (2) @(posedge clk);
        #1 check(init_phase, 1'b1);
        wrap_up();
    end
endmodule
